// ### hw/ext_mem_interface.sv
// external data memory interface: mode decode, address drive and access timing
//
// Contract
// - mode 00 sends every access on-chip
// - internal mode wraps address into on-chip RAM
// - byte access uses page high, pointer low
// - split modes decode by on-chip RAM boundary
// - no-bank byte access leaves A[11:8] undriven
// - split wide access drives A[11:0]
// - bank mode byte access drives page on A[11:8]
// - split byte access off-chip when page MSB set
// - mode 11 sends every access off-chip
// - external byte access ignores page, A[11:8] floats
// - external wide access drives all sixteen lines
// - setup, hold, strobe, latch widths programmable
// - access lasts programmed timing plus four cycles
// - multiplexed access adds latch phases, minimum seven
// - reset sets setup and hold to maximum
// - page register gives high byte, field 4:0
// - page register upper three bits read zero
// - latch high and low each field plus one
// - setup and hold equal field value
// - strobe lasts field value plus one
// - pins owned only while off-chip access runs
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module ext_mem_interface #(
  parameter int unsigned RAM_SIZE = 4096,
  parameter int unsigned RAM_AW   = $clog2(RAM_SIZE)
) (
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  input  wire logic [7:0]             regAddr,
  input  wire logic [7:0]             regWrData,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output var  logic [7:0]             regRdData,
  input  wire logic                   muxedBus,
  input  wire logic                   reqValid,
  output var  logic                   reqReady,
  input  wire logic                   reqWrite,
  input  wire logic                   reqWide,
  input  wire logic [15:0]            reqPointer,
  input  wire logic [7:0]             reqWrData,
  output var  logic                   reqDone,
  output var  logic [7:0]             reqRdData,
  output var  logic                   ramEn,
  output var  logic                   ramWe,
  output var  logic [RAM_AW-1:0]      ramAddr,
  output var  logic [7:0]             ramWrData,
  input  wire logic [7:0]             ramRdData,
  output var  logic                   pinOwn,
  output var  logic [3:0]             addrUpOut,
  output var  logic                   addrUpOe,
  output var  logic [3:0]             addrMidOut,
  output var  logic                   addrMidOe,
  output var  logic [7:0]             addrLoOut,
  output var  logic                   addrLoOe,
  output var  logic [7:0]             adOut,
  output var  logic                   adOe,
  input  wire logic [7:0]             adIn,
  output var  logic                   addrLatchOut,
  output var  logic                   rdOutN,
  output var  logic                   wrOutN
);
  import ext_mem_pkg::*;

  // boundary compared against a 16-bit pointer; wrap assumes a power of two
  localparam logic [16:0] RAM_LIMIT = 17'(RAM_SIZE);

  // ********************************************************************
  // registers
  // ********************************************************************
  logic [PAGE_W-1:0]   pageSelect;
  logic [CONFIG_W-1:0] cfgBits;
  logic [7:0]          timing;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pageSelect <= PAGE_RESET[PAGE_W-1:0];
      cfgBits    <= CONFIG_RESET;
      timing     <= TIMING_RESET;
    end else if (regWr) begin
      unique case (regAddr)
        PAGE_REG_ADDR:   pageSelect <= regWrData[PAGE_W-1:0];
        CONFIG_REG_ADDR: cfgBits    <= regWrData[CONFIG_W-1:0];
        TIMING_REG_ADDR: timing     <= regWrData;
        default: ;
      endcase
    end
  end

  // read data stands for exactly one cycle; unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        PAGE_REG_ADDR:   regRdData <= {3'h0, pageSelect};
        CONFIG_REG_ADDR: regRdData <= {4'h0, cfgBits};
        TIMING_REG_ADDR: regRdData <= timing;
        default:         regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

  // ********************************************************************
  // request decode
  // ********************************************************************
  op_mode_t    cfgMode;
  logic [15:0] effAddr;
  logic        goesOff;
  logic        accept;

  assign cfgMode = op_mode_t'(cfgBits[MODE_LSB +: 2]);
  assign effAddr = reqWide ? reqPointer : {3'h0, pageSelect, reqPointer[7:0]};
  assign accept  = reqValid && reqReady;

  always_comb begin
    unique case (cfgMode)
      MODE_INTERNAL: goesOff = 1'b0;
      MODE_EXTERNAL: goesOff = 1'b1;
      default:       goesOff = reqWide ? ({1'b0, reqPointer} >= RAM_LIMIT)
                                       : pageSelect[PAGE_MSB];
    endcase
  end

  // ********************************************************************
  // access snapshot
  // ********************************************************************
  // timing and mode are frozen at acceptance so a register write cannot
  // reshape an access already on the pins
  op_mode_t   accMode;
  logic       accWide;
  logic       accWrite;
  logic       accMuxed;
  logic       accOff;
  logic [1:0] setupCyc;
  logic [3:0] strobeCyc;
  logic [1:0] holdCyc;
  logic [1:0] latchCyc;
  logic [5:0] accExpect;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      accMode   <= MODE_INTERNAL;
      accWide   <= 1'b0;
      accWrite  <= 1'b0;
      accMuxed  <= 1'b0;
      accOff    <= 1'b0;
      setupCyc  <= 2'h0;
      strobeCyc <= 4'h0;
      holdCyc   <= 2'h0;
      latchCyc  <= 2'h0;
      accExpect <= 6'h00;
      ramWrData <= 8'h00;
      ramAddr   <= '0;
      addrUpOut <= 4'h0;
      addrMidOut <= 4'h0;
      addrLoOut <= 8'h00;
    end else if (accept) begin
      accMode   <= cfgMode;
      accWide   <= reqWide;
      accWrite  <= reqWrite;
      accMuxed  <= muxedBus;
      accOff    <= goesOff;
      setupCyc  <= timing[SETUP_LSB +: 2];
      strobeCyc <= timing[STROBE_LSB +: 4];
      holdCyc   <= timing[HOLD_LSB +: 2];
      latchCyc  <= cfgBits[LATCH_LSB +: 2];
      accExpect <= FIXED_OVERHEAD + 6'(timing[SETUP_LSB +: 2]) + 6'(timing[STROBE_LSB +: 4]) + 6'h01
                 + 6'(timing[HOLD_LSB +: 2])
                 + (muxedBus ? 6'({cfgBits[LATCH_LSB +: 2], 1'b0}) + 6'h02 : 6'h00);
      ramWrData <= reqWrData;
      ramAddr   <= effAddr[RAM_AW-1:0];
      addrUpOut <= effAddr[15:12];
      addrMidOut <= effAddr[11:8];
      addrLoOut <= effAddr[7:0];
    end
  end

  // ********************************************************************
  // phase sequencer
  // ********************************************************************
  phase_t     state;
  logic [3:0] phaseCnt;
  phase_t     nextPhase;

  // zero-length setup and hold phases are skipped outright
  function automatic phase_t stepFrom(phase_t s, logic mx, logic [1:0] su, logic [1:0] hd);
    phase_t n;
    n = S_IDLE;
    unique case (s)
      S_LAUNCH:     n = (su != 2'h0) ? S_SETUP : (mx ? S_LATCH_HIGH : S_STROBE);
      S_SETUP:      n = mx ? S_LATCH_HIGH : S_STROBE;
      S_LATCH_HIGH: n = S_LATCH_LOW;
      S_LATCH_LOW:  n = S_STROBE;
      S_STROBE:     n = (hd != 2'h0) ? S_HOLD : S_TAIL;
      S_HOLD:       n = S_TAIL;
      default:      n = S_IDLE;
    endcase
    return n;
  endfunction : stepFrom

  // cycles spent in a phase, less one
  function automatic logic [3:0] phaseLast(phase_t s, logic [1:0] su, logic [3:0] sw,
                                            logic [1:0] hd, logic [1:0] la);
    logic [3:0] n;
    n = PHASE_ZERO;
    unique case (s)
      S_SETUP:      n = {2'h0, su} - PHASE_ONE;
      S_LATCH_HIGH: n = {2'h0, la};
      S_LATCH_LOW:  n = {2'h0, la};
      S_STROBE:     n = sw;
      S_HOLD:       n = {2'h0, hd} - PHASE_ONE;
      S_TAIL:       n = TAIL_LAST;
      default:      n = PHASE_ZERO;
    endcase
    return n;
  endfunction : phaseLast

  assign nextPhase = stepFrom(state, accMuxed, setupCyc, holdCyc);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state    <= S_IDLE;
      phaseCnt <= PHASE_ZERO;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (accept) begin
            state    <= goesOff ? S_LAUNCH : S_RAM;
            phaseCnt <= PHASE_ZERO;
          end
        end
        S_RAM:      state <= S_RAM_WAIT;
        S_RAM_WAIT: state <= S_IDLE;
        default: begin
          if (phaseCnt != PHASE_ZERO) begin
            phaseCnt <= phaseCnt - PHASE_ONE;
          end else begin
            state    <= nextPhase;
            phaseCnt <= phaseLast(nextPhase, setupCyc, strobeCyc, holdCyc, latchCyc);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reqDone <= 1'b0;
    end else begin
      reqDone <= (state == S_RAM_WAIT) || (state == S_TAIL && phaseCnt == PHASE_ZERO);
    end
  end

  // ********************************************************************
  // read data capture
  // ********************************************************************
  // the data pins pass two flops, so a tap two cycles behind the last
  // strobe cycle catches what the pins showed at the strobe's end
  logic [7:0] adInMeta;
  logic [7:0] adInSync;
  logic [1:0] capPipe;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      adInMeta <= 8'h00;
      adInSync <= 8'h00;
    end else begin
      adInMeta <= adIn;
      adInSync <= adInMeta;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      capPipe <= 2'h0;
    end else begin
      capPipe <= {capPipe[0], state == S_STROBE && phaseCnt == PHASE_ZERO && !accWrite};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reqRdData <= 8'h00;
    end else if (state == S_RAM_WAIT && !accWrite) begin
      reqRdData <= ramRdData;
    end else if (capPipe[1]) begin
      reqRdData <= adInSync;
    end
  end

  // multiplexed pins carry the low address first, write data after the latch falls
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      adOut <= 8'h00;
    end else if (accept) begin
      adOut <= muxedBus ? effAddr[7:0] : reqWrData;
    end else if (state == S_LATCH_HIGH && phaseCnt == PHASE_ZERO) begin
      adOut <= ramWrData;
    end
  end

  // ********************************************************************
  // pin control
  // ********************************************************************
  logic addrPhase;
  logic bodyPhase;

  assign reqReady  = (state == S_IDLE);
  assign ramEn     = (state == S_RAM);
  assign ramWe     = ramEn && accWrite;
  assign pinOwn    = (state >= S_LAUNCH);
  assign addrPhase = (state == S_LAUNCH) || (state == S_SETUP) || (state == S_LATCH_HIGH);
  assign bodyPhase = pinOwn && (state != S_TAIL);

  assign addrUpOe     = pinOwn && accWide && (accMode == MODE_EXTERNAL);
  assign addrMidOe    = pinOwn && (accWide || accMode == MODE_SPLIT_BANK);
  assign addrLoOe     = pinOwn && !accMuxed;
  assign adOe         = accMuxed ? ((state == S_LAUNCH) || (state == S_SETUP) || (state == S_LATCH_HIGH)
                                    || (bodyPhase && accWrite))
                                 : (bodyPhase && accWrite);
  assign addrLatchOut = (state == S_LATCH_HIGH);
  assign rdOutN       = !(state == S_STROBE && !accWrite);
  assign wrOutN       = !(state == S_STROBE && accWrite);

  // ********************************************************************
  // assertions
  // ********************************************************************
  logic [5:0] ownCycles;
  logic [3:0] strobeRun;
  logic [2:0] latchRun;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ownCycles <= 6'h00;
      strobeRun <= 4'h0;
      latchRun  <= 3'h0;
    end else begin
      ownCycles <= pinOwn ? ownCycles + 6'h01 : 6'h00;
      strobeRun <= (state == S_STROBE) ? strobeRun + 4'h1 : 4'h0;
      latchRun  <= (state == S_LATCH_HIGH) ? latchRun + 3'h1 : 3'h0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_internal_stays;
    accept && cfgMode == MODE_INTERNAL |=> ramEn ##1 !pinOwn ##1 reqReady;
  endproperty
  a_internal_stays: assert property (p_internal_stays) else $error("internal mode reached pins");

  property p_wrap;
    accept && cfgMode == MODE_INTERNAL |=> ramAddr == $past(reqPointer[RAM_AW-1:0]) || !$past(reqWide);
  endproperty
  a_wrap: assert property (p_wrap) else $error("internal address not wrapped");

  property p_split_decode;
    accept && (cfgMode == MODE_SPLIT_NOBANK || cfgMode == MODE_SPLIT_BANK)
      |=> pinOwn == (($past(reqWide) && {1'b0, $past(reqPointer)} >= RAM_LIMIT)
                     || (!$past(reqWide) && $past(pageSelect[PAGE_MSB])));
  endproperty
  a_split_decode: assert property (p_split_decode) else $error("split decode wrong");

  property p_bank_page;
    accept && !reqWide && cfgMode == MODE_SPLIT_BANK && pageSelect[PAGE_MSB]
      |=> addrMidOe && addrMidOut == $past(pageSelect[3:0]) && addrLoOut == $past(reqPointer[7:0]);
  endproperty
  a_bank_page: assert property (p_bank_page) else $error("page not on upper address");

  property p_byte_float;
    pinOwn && !accWide && accMode != MODE_SPLIT_BANK |-> !addrMidOe && !addrUpOe;
  endproperty
  a_byte_float: assert property (p_byte_float) else $error("upper address driven");

  property p_wide_drive;
    pinOwn && accWide |-> addrMidOe && (addrUpOe == (accMode == MODE_EXTERNAL));
  endproperty
  a_wide_drive: assert property (p_wide_drive) else $error("wide address lines wrong");

  property p_external_all;
    accept && cfgMode == MODE_EXTERNAL |=> pinOwn && !ramEn;
  endproperty
  a_external_all: assert property (p_external_all) else $error("external mode went on-chip");

  property p_duration;
    reqDone && accOff |-> ownCycles == accExpect;
  endproperty
  a_duration: assert property (p_duration) else $error("off-chip access length wrong");

  property p_strobe_width;
    $past(state) == S_STROBE && state != S_STROBE |-> strobeRun == strobeCyc + 4'h1;
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");

  property p_latch_width;
    $fell(addrLatchOut) |-> latchRun == {1'b0, latchCyc} + 3'h1;
  endproperty
  a_latch_width: assert property (p_latch_width) else $error("latch width wrong");

  property p_release;
    reqDone |-> !pinOwn && !adOe && !addrMidOe && !addrLoOe ##1 (!pinOwn || $past(accept));
  endproperty
  a_release: assert property (p_release) else $error("pins kept after access");

  property p_page_read;
    $past(regRd) && $past(regAddr) == PAGE_REG_ADDR |-> regRdData[7:5] == 3'h0;
  endproperty
  a_page_read: assert property (p_page_read) else $error("page upper bits not zero");

  c_internal:  cover property (accept && cfgMode == MODE_INTERNAL);
  c_bank_byte: cover property (accept && cfgMode == MODE_SPLIT_BANK && !reqWide && goesOff);
  c_mux_write: cover property (accept && muxedBus && reqWrite && goesOff ##[5:40] reqDone);
  c_ext_wide:  cover property (accept && cfgMode == MODE_EXTERNAL && reqWide);

endmodule : ext_mem_interface

`default_nettype wire

// ### include/ext_mem_pkg.sv
// constants, register map and types shared by the external data memory interface
package ext_mem_pkg;

  // ********************************************************************
  // register map
  // ********************************************************************
  localparam logic [7:0] PAGE_REG_ADDR   = 8'haa;
  localparam logic [7:0] CONFIG_REG_ADDR = 8'hab;
  localparam logic [7:0] TIMING_REG_ADDR = 8'haf;

  localparam logic [7:0] PAGE_RESET   = 8'h00;
  localparam logic [3:0] CONFIG_RESET = 4'h3;
  // setup and hold come out of reset at their slowest settings
  localparam logic [7:0] TIMING_RESET = 8'hff;

  // ********************************************************************
  // field layout
  // ********************************************************************
  localparam int unsigned PAGE_W       = 5;
  localparam int unsigned PAGE_MSB     = 4;
  localparam int unsigned CONFIG_W     = 4;
  localparam int unsigned MODE_LSB     = 2;
  localparam int unsigned LATCH_LSB    = 0;
  localparam int unsigned SETUP_LSB    = 6;
  localparam int unsigned STROBE_LSB   = 2;
  localparam int unsigned HOLD_LSB     = 0;

  // ********************************************************************
  // timing
  // ********************************************************************
  // fixed overhead of an off-chip access: one launch cycle plus the tail
  localparam logic [5:0] FIXED_OVERHEAD = 6'h04;
  localparam logic [3:0] TAIL_LAST      = 4'h2;
  localparam logic [3:0] PHASE_ZERO     = 4'h0;
  localparam logic [3:0] PHASE_ONE      = 4'h1;

  typedef enum logic [1:0] {
    MODE_INTERNAL     = 2'b00,
    MODE_SPLIT_NOBANK = 2'b01,
    MODE_SPLIT_BANK   = 2'b10,
    MODE_EXTERNAL     = 2'b11
  } op_mode_t;

  typedef enum logic [3:0] {
    S_IDLE       = 4'b0000,
    S_RAM        = 4'b0001,
    S_RAM_WAIT   = 4'b0010,
    S_LAUNCH     = 4'b0011,
    S_SETUP      = 4'b0100,
    S_LATCH_HIGH = 4'b0101,
    S_LATCH_LOW  = 4'b0110,
    S_STROBE     = 4'b0111,
    S_HOLD       = 4'b1000,
    S_TAIL       = 4'b1001
  } phase_t;

endpackage : ext_mem_pkg

// ### sim/ext_sram_model.sv
// behavioural off-chip byte memory hanging on the shared address and data pins
`timescale 1ns/1ps
`default_nettype none

module ext_sram_model (
  input  wire logic       clk_sys,
  input  wire logic       muxedBus,
  input  wire logic [3:0] addrUpOut,
  input  wire logic       addrUpOe,
  input  wire logic [3:0] addrMidOut,
  input  wire logic       addrMidOe,
  input  wire logic [7:0] addrLoOut,
  input  wire logic       addrLoOe,
  input  wire logic [7:0] adOut,
  input  wire logic       adOe,
  input  wire logic       addrLatchOut,
  input  wire logic       rdOutN,
  input  wire logic       wrOutN,
  output var  logic [7:0] adIn
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  latched = 8'h00;
  logic [7:0]  last    = 8'h00;
  logic [15:0] addr;

  // ********************************************************************
  // address seen by the memory
  // ********************************************************************
  // lines the interface does not drive sit at the parked port level of 1
  always_comb begin
    addr = {addrUpOe ? addrUpOut : 4'hf, addrMidOe ? addrMidOut : 4'hf, 8'hff};
    addr[7:0] = muxedBus ? latched : (addrLoOe ? addrLoOut : 8'hff);
  end

  always_ff @(posedge clk_sys) begin
    if (addrLatchOut && adOe) begin
      latched <= adOut;
    end
    if (!wrOutN) begin
      mem[addr] <= adOut;
    end
    if (!rdOutN) begin
      last <= mem[addr];
    end
  end

  // a released bus must not keep looking like valid read data
  always_comb adIn = !rdOutN ? mem[addr] : ~last;
endmodule : ext_sram_model

`default_nettype wire

// ### sim/tb_top.sv
// testbench for the external data memory interface: registers, decode, address drive and timing
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import ext_mem_pkg::*;
  logic        clk_sys, arst_n, regWr, regRd, muxedBus, reqValid, reqWrite, reqWide;
  logic [7:0]  regAddr, regWrData, regRdData, reqWrData, reqRdData, ramWrData, ramRdData;
  logic [7:0]  addrLoOut, adOut, adIn;
  logic [15:0] reqPointer, stbAddr, ramAt, d;
  logic [11:0] ramAddr;
  logic        reqReady, reqDone, ramEn, ramWe, pinOwn, addrUpOe, addrMidOe, addrLoOe, adOe;
  logic        addrLatchOut, rdOutN, wrOutN, ramSeen, midOe, upOe;
  logic [8:0]  ramWr;
  logic [3:0]  addrUpOut, addrMidOut;
  logic [7:0]  tt [4] = '{8'h00, 8'h4d, 8'hb6, 8'hff};
  int          n_mismatch, n_compared, nCyc, nOwn, nStb, nLat, firstStb, n;

  ext_mem_interface #(.RAM_SIZE(4096)) uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .muxedBus(muxedBus), .reqValid(reqValid), .reqReady(reqReady),
    .reqWrite(reqWrite), .reqWide(reqWide), .reqPointer(reqPointer), .reqWrData(reqWrData),
    .reqDone(reqDone), .reqRdData(reqRdData), .ramEn(ramEn), .ramWe(ramWe), .ramAddr(ramAddr),
    .ramWrData(ramWrData), .ramRdData(ramRdData), .pinOwn(pinOwn), .addrUpOut(addrUpOut),
    .addrUpOe(addrUpOe), .addrMidOut(addrMidOut), .addrMidOe(addrMidOe), .addrLoOut(addrLoOut),
    .addrLoOe(addrLoOe), .adOut(adOut), .adOe(adOe), .adIn(adIn), .addrLatchOut(addrLatchOut),
    .rdOutN(rdOutN), .wrOutN(wrOutN));

  ext_sram_model partner (
    .clk_sys(clk_sys), .muxedBus(muxedBus), .addrUpOut(addrUpOut), .addrUpOe(addrUpOe),
    .addrMidOut(addrMidOut), .addrMidOe(addrMidOe), .addrLoOut(addrLoOut), .addrLoOe(addrLoOe),
    .adOut(adOut), .adOe(adOe), .addrLatchOut(addrLatchOut), .rdOutN(rdOutN), .wrOutN(wrOutN), .adIn(adIn));

  // on-chip ram stand-in: content is a fixed function of the address
  assign ramRdData = ramAddr[7:0] ^ 8'h5a;

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ********************************************************************
  // shared tasks
  // ********************************************************************
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= v;
    regWr     <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    d = {8'h00, regRdData};
  endtask : reg_rd

  // one access; counts owned, strobe and latch cycles and grabs the address at the first strobe cycle
  task automatic access(input logic mx, input logic wr, input logic wide, input logic [15:0] p, input logic [7:0] wd);
    int i;
    @(posedge clk_sys);
    {muxedBus, reqWrite, reqWide, reqPointer, reqWrData} <= {mx, wr, wide, p, wd};
    reqValid <= 1'b1;
    nOwn = 0;
    nStb = 0;
    nLat = 0;
    ramSeen = 1'b0;
    @(posedge clk_sys);
    reqValid <= 1'b0;
    ramWr = 9'h000;
    // sampling starts in the cycle right after the taking edge, so i counts cycles from there
    for (i = 1; i <= 60; i++) begin
      #1;
      if (pinOwn) nOwn++;
      if (addrLatchOut) nLat++;
      if (ramEn) begin
        ramSeen = 1'b1;
        ramAt = {4'h0, ramAddr};
        ramWr = {ramWe, ramWrData};
      end
      if ((!rdOutN || !wrOutN) && nStb++ == 0) begin
        firstStb = i;
        midOe = addrMidOe;
        upOe = addrUpOe;
        stbAddr = {addrUpOut, addrMidOut, addrLoOut};
      end
      if (reqDone) break;
      @(posedge clk_sys);
    end
    if (i > 60) begin
      n_mismatch++;
      $display("mismatch reqDone expected 1 seen 0");
      end_of_test();
    end
    nCyc = i;
    check("released", {11'h0, pinOwn, addrUpOe, addrMidOe, addrLoOe, adOe}, 16'h0);
  endtask : access

  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    {arst_n, regWr, regRd, muxedBus, reqValid, reqWrite, reqWide} = '0;
    {regAddr, regWrData, reqWrData, reqPointer} = '0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    reg_rd(PAGE_REG_ADDR);    check("page", d, 16'h00);
    reg_rd(CONFIG_REG_ADDR);  check("config", d, 16'h03);
    reg_rd(TIMING_REG_ADDR);  check("timing", d, 16'hff);
    reg_rd(8'h10);            check("unmapped", d, 16'h00);
    reg_wr(PAGE_REG_ADDR, 8'hff);
    reg_rd(PAGE_REG_ADDR);    check("page", d, 16'h1f);
    // internal only: off-chip pins never claimed, high addresses wrap
    access(1'b0, 1'b0, 1'b1, 16'h1234, 8'h00);
    check("cycles", 16'(nCyc), 16'd3);
    check("owned", 16'(nOwn), 16'd0);
    check("ramAddr", ramAt, 16'h0234);
    check("rdata", {8'h00, reqRdData}, 16'h6e);
    reg_wr(PAGE_REG_ADDR, 8'h05);
    access(1'b0, 1'b0, 1'b0, 16'h0077, 8'h00);
    check("ramAddr", ramAt, 16'h0577);
    access(1'b0, 1'b1, 1'b0, 16'h0077, 8'ha5);
    check("ramWr", {7'h00, ramWr}, 16'h01a5);
    // external only, first at reset timing then at zero timing, non-multiplexed
    reg_wr(CONFIG_REG_ADDR, 8'h0c);
    access(1'b0, 1'b1, 1'b1, 16'habcd, 8'h3c);
    check("owned", 16'(nOwn), 16'd26);
    check("strobe", 16'(nStb), 16'd16);
    check("addr", stbAddr, 16'habcd);
    reg_wr(TIMING_REG_ADDR, 8'h00);
    access(1'b0, 1'b0, 1'b1, 16'habcd, 8'h00);
    check("rdata", {8'h00, reqRdData}, 16'h3c);
    check("owned", 16'(nOwn), 16'd5);
    check("cycles", 16'(nCyc), 16'd6);
    access(1'b0, 1'b0, 1'b1, 16'h0010, 8'h00);
    check("onchip", {15'h0, ramSeen}, 16'h0);
    check("upOe", {15'h0, upOe}, 16'h1);
    access(1'b0, 1'b1, 1'b0, 16'h0066, 8'h11);
    check("midOe", {15'h0, midOe}, 16'h0);
    check("addrLo", {8'h00, stbAddr[7:0]}, 16'h66);
    // split without bank select
    reg_wr(CONFIG_REG_ADDR, 8'h04);
    reg_wr(PAGE_REG_ADDR, 8'h11);
    access(1'b0, 1'b1, 1'b0, 16'h0022, 8'h99);
    check("owned", 16'(nOwn), 16'd5);
    check("midOe", {15'h0, midOe}, 16'h0);
    check("addrLo", {8'h00, stbAddr[7:0]}, 16'h22);
    reg_wr(PAGE_REG_ADDR, 8'h01);
    access(1'b0, 1'b0, 1'b0, 16'h0022, 8'h00);
    check("owned", 16'(nOwn), 16'd0);
    check("ramAddr", ramAt, 16'h0122);
    access(1'b0, 1'b0, 1'b1, 16'h0fff, 8'h00);
    check("ramAddr", ramAt, 16'h0fff);
    access(1'b0, 1'b0, 1'b1, 16'h1000, 8'h00);
    check("onchip", {15'h0, ramSeen}, 16'h0);
    check("addr", {4'h0, stbAddr[11:0]}, 16'h0000);
    check("midOe", {15'h0, midOe}, 16'h1);
    // split with bank select
    reg_wr(CONFIG_REG_ADDR, 8'h08);
    reg_wr(PAGE_REG_ADDR, 8'h13);
    access(1'b0, 1'b0, 1'b0, 16'h0044, 8'h00);
    check("addr", {4'h0, stbAddr[11:0]}, 16'h0344);
    check("midOe", {15'h0, midOe}, 16'h1);
    reg_wr(PAGE_REG_ADDR, 8'h03);
    access(1'b0, 1'b0, 1'b0, 16'h0044, 8'h00);
    check("ramAddr", ramAt, 16'h0344);
    // multiplexed timing sweep, latch width stepping with each setting
    for (int k = 0; k < 4; k++) begin
      reg_wr(CONFIG_REG_ADDR, {6'h03, k[1:0]});
      reg_wr(TIMING_REG_ADDR, tt[k]);
      access(1'b1, k[0], 1'b1, 16'h0123, 8'h5c);
      n = tt[k][7:6] + tt[k][5:2] + 1 + tt[k][1:0] + 4 + 2 * (k + 1);
      check("owned", 16'(nOwn), 16'(n));
      check("strobe", 16'(nStb), 16'(tt[k][5:2] + 1));
      check("latch", 16'(nLat), 16'(k + 1));
      check("order", 16'(firstStb), 16'(2 + tt[k][7:6] + 2 * (k + 1)));
    end
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
